// File: common/phy_startup_pkg.sv
// Constants, encodings and state types shared by the start-up reset sequencer
//
// Summary of operation
// - Leave reset once POR and pin high
// - Pin low one microsecond resets everything
// - Core supply cycling reloads register defaults
// - Power-on default is synchronous mode, clock running
// - Start needs supplies, reference clock, pin high
// - Pin release synchronised, may be asynchronous
// - Idle on bus, DIR high until lock
// - After lock, check STP low, drop DIR
// - STP held high keeps DIR high
// - Late reference clock restarts start-up timing
// - No 3.3 V: register access only
// - No core supply: interface stays inactive
// - UART mode sets regulator level field
// - Interface clock derived from reference clock
package phy_startup_pkg;

   // System clock and the shortest honoured reset pulse
   localparam int MCLK_PERIOD_NS   = 40;
   localparam int T_RESET_MIN_NS   = 1000;
   localparam int RESET_MIN_CYCLES = (T_RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // Counter holding how long the reset pin has been low
   localparam int             RESET_CNT_W     = 8;
   localparam logic [RESET_CNT_W-1:0] RESET_MIN_COUNT = RESET_CNT_W'(RESET_MIN_CYCLES);

   // Link bus values
   localparam int          ULPI_DATA_W    = 8;
   localparam logic [7:0]  ULPI_IDLE_BYTE = 8'h00;

   // Regulator level code used outside UART mode and after reset
   localparam logic [1:0]  REG_LEVEL_DEFAULT = 2'h0;

   // System-side sequencer states
   typedef enum logic [1:0] {
      SEQ_RESET,
      SEQ_WAIT_REF,
      SEQ_START,
      SEQ_RUN
   } seq_state_t;

   // Link-side bus ownership states
   typedef enum logic [1:0] {
      LNK_HOLD,
      LNK_WAIT_STP,
      LNK_RUN
   } link_state_t;

endpackage

// File: verilog/bit_sync.sv
// Two flip-flop synchroniser with asynchronous reset to a constant
`timescale 1ns/1ns
module bit_sync
   import phy_startup_pkg::*;
#(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             arst,
   // Data crossing in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   ////////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second stage
   always_comb
   begin
      next_state        = state;
      next_state.first  = d;
      next_state.second = state.first;
   end

   // Both stages take the constant under reset
   always_ff @(posedge clk or posedge arst)
   begin
      if (arst)
      begin
         state <= {RESET_VALUE, RESET_VALUE};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign q = state.second;

endmodule

// File: verilog/phy_startup_reset_sequencer.sv
// Reset combining, supply qualification and link bus hand-over at start-up
`timescale 1ns/1ns
module phy_startup_reset_sequencer
   import phy_startup_pkg::*;
#(
   parameter int STARTUP_CYCLES     = 256,
   parameter int REF_TIMEOUT_CYCLES = 64,
   parameter int START_CNT_W        = 16,
   parameter int REF_CNT_W          = 8
)
(
   // System clock and reset
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   // Interface clock from the PLL
   input  wire logic                   interface_clk,
   // Power and reset status, all asynchronous
   input  wire logic                   por_done,
   input  wire logic                   ext_reset_low_pin,
   input  wire logic                   core_supply_1v8,
   input  wire logic                   usb_supply_3v3,
   input  wire logic                   io_supply,
   // Reference clock pin, sampled as a level
   input  wire logic                   reference_clock_in,
   // PLL status, asynchronous
   input  wire logic                   pll_lock,
   // Link control, on the interface clock
   input  wire logic                   stp,
   // UART regulator control, on the system clock
   input  wire logic                   uart_mode,
   input  wire logic [1:0]             uart_level_field,
   // Start-up and mode status
   output logic                        pll_enable,
   output logic                        interface_reset_low,
   output logic                        usb_operation_allowed,
   output logic                        register_access_only,
   output logic [1:0]                  uart_regulator_level,
   // Link bus, device side
   output logic                        dir,
   output logic [ULPI_DATA_W-1:0]      data_out,
   output logic                        data_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // System clock domain state
   typedef struct packed {
      seq_state_t             state;
      logic [RESET_CNT_W-1:0] low_cnt;
      logic                   ref_prev;
      logic [REF_CNT_W-1:0]   ref_cnt;
      logic                   ref_present;
      logic [START_CNT_W-1:0] start_cnt;
      logic                   core_reset_req;
      logic                   seq_run;
      logic                   pll_enable;
      logic                   usb_allowed;
      logic                   reg_only;
      logic [1:0]             reg_level;
   } sys_state_t;

   localparam sys_state_t SYS_INIT = '{
      state          : SEQ_RESET,
      low_cnt        : '0,
      ref_prev       : 1'b0,
      ref_cnt        : '0,
      ref_present    : 1'b0,
      start_cnt      : '0,
      core_reset_req : 1'b1,
      seq_run        : 1'b0,
      pll_enable     : 1'b0,
      usb_allowed    : 1'b0,
      reg_only       : 1'b0,
      reg_level      : REG_LEVEL_DEFAULT
   };
   localparam logic [REF_CNT_W-1:0]   REF_TIMEOUT = REF_CNT_W'(REF_TIMEOUT_CYCLES);
   localparam logic [START_CNT_W-1:0] START_LAST  = START_CNT_W'(STARTUP_CYCLES - 1);
   sys_state_t sys_q;
   sys_state_t next_sys;
   // Synchronised pins
   logic por_s;
   logic pin_s;
   logic core_s;
   logic usb_s;
   logic io_s;
   logic ref_s;
   logic [5:0] pins_sync;
   // Derived conditions
   logic hard_off;
   logic pin_reset;
   logic ref_edge;

   ////////////////////////////////////////////////////////////////////////////////
   // Interface clock domain state
   typedef struct packed {
      link_state_t             state;
      logic                    dir;
      logic [ULPI_DATA_W-1:0]  data_out;
      logic                    data_oe;
   } link_reg_t;

   localparam link_reg_t LINK_INIT = '{
      state    : LNK_HOLD,
      dir      : 1'b0,
      data_out : ULPI_IDLE_BYTE,
      data_oe  : 1'b0
   };
   link_reg_t link_q;
   link_reg_t next_link;
   logic       link_arst;
   logic       link_rst_n;
   logic       lock_s;
   logic       run_s;
   logic [1:0] link_sync;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers on the system clock
   // release synchronised here
   bit_sync #(
      .WIDTH       (6),
      .RESET_VALUE (6'h00)
   ) u_pin_sync (
      .clk  (mclk),
      .arst (sys_rst),
      .d    ({por_done, ext_reset_low_pin, core_supply_1v8,
              usb_supply_3v3, io_supply, reference_clock_in}),
      .q    (pins_sync)
   );
   assign {por_s, pin_s, core_s, usb_s, io_s, ref_s} = pins_sync;

   ////////////////////////////////////////////////////////////////////////////////
   // Conditions feeding the sequencer
   // missing core supply forces reset
   assign hard_off = !por_s || !core_s || !io_s;

   // long low pulse resets
   // Shorter dips are treated as noise so a glitch cannot kill a running link
   // The sample now being taken counts too, so a pulse of exactly the minimum is honoured
   assign pin_reset = !pin_s && ((sys_q.low_cnt >= (RESET_MIN_COUNT - RESET_CNT_W'(1)))
                                 || (sys_q.state == SEQ_RESET));
   assign ref_edge = ref_s && !sys_q.ref_prev;

   ////////////////////////////////////////////////////////////////////////////////
   // System-side sequencer next state
   always_comb
   begin
      next_sys          = sys_q;
      next_sys.ref_prev = ref_s;
      // Saturating low-time counter for the reset pin
      if (pin_s)
      begin
         next_sys.low_cnt = '0;
      end
      else if (sys_q.low_cnt != RESET_MIN_COUNT)
      begin
         next_sys.low_cnt = sys_q.low_cnt + RESET_CNT_W'(1);
      end
      // Reference clock presence; a sampled edge refreshes the watchdog.
      // Sampling a near-equal clock beats, so the timeout must exceed the beat period.
      if (ref_edge)
      begin
         next_sys.ref_cnt     = '0;
         next_sys.ref_present = 1'b1;
      end
      else if (sys_q.ref_cnt == REF_TIMEOUT)
      begin
         next_sys.ref_present = 1'b0;
      end
      else
      begin
         next_sys.ref_cnt = sys_q.ref_cnt + REF_CNT_W'(1);
      end
      case (sys_q.state)
         SEQ_RESET:
         begin
            next_sys.start_cnt = '0;
            if (!hard_off && pin_s)
            begin
               next_sys.state = SEQ_WAIT_REF;
            end
         end
         SEQ_WAIT_REF:
         begin
            next_sys.start_cnt = '0;
            if (sys_q.ref_present)
            begin
               next_sys.state = SEQ_START;
            end
         end
         SEQ_START:
         begin
            if (!sys_q.ref_present)
            begin
               next_sys.state     = SEQ_WAIT_REF;
               next_sys.start_cnt = '0;
            end
            else if (sys_q.start_cnt == START_LAST)
            begin
               next_sys.state = SEQ_RUN;
            end
            else
            begin
               next_sys.start_cnt = sys_q.start_cnt + START_CNT_W'(1);
            end
         end
         SEQ_RUN:
         begin
            next_sys.start_cnt = '0;
         end
         default:
         begin
            next_sys.state = SEQ_RESET;
         end
      endcase
      if (hard_off || pin_reset)
      begin
         next_sys.state     = SEQ_RESET;
         next_sys.start_cnt = '0;
      end
      next_sys.core_reset_req = (next_sys.state == SEQ_RESET);
      next_sys.seq_run        = (next_sys.state == SEQ_RUN);

      next_sys.pll_enable = (next_sys.state == SEQ_START) || (next_sys.state == SEQ_RUN);

      next_sys.usb_allowed = next_sys.seq_run && usb_s;
      next_sys.reg_only    = next_sys.seq_run && !usb_s;

      if (uart_mode && next_sys.seq_run)
      begin
         next_sys.reg_level = uart_level_field;
      end
      else
      begin
         next_sys.reg_level = REG_LEVEL_DEFAULT;
      end
   end

   // System-side state register
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sys_q <= SYS_INIT;
      end
      else
      begin
         sys_q <= next_sys;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset and status crossing into the interface clock domain
   // Reset asserts at once, from a register, and releases on the interface clock
   assign link_arst = sys_rst || sys_q.core_reset_req;

   bit_sync #(
      .WIDTH       (1),
      .RESET_VALUE (1'b0)
   ) u_reset_sync (
      .clk  (interface_clk),
      .arst (link_arst),
      .d    (1'b1),
      .q    (link_rst_n)
   );

   // PLL lock is analog and the run flag is on the system clock
   bit_sync #(
      .WIDTH       (2),
      .RESET_VALUE (2'h0)
   ) u_link_sync (
      .clk  (interface_clk),
      .arst (link_arst),
      .d    ({pll_lock, sys_q.seq_run}),
      .q    (link_sync)
   );
   assign {lock_s, run_s} = link_sync;

   ////////////////////////////////////////////////////////////////////////////////
   // Link-side bus hand-over next state
   always_comb
   begin
      next_link = link_q;
      case (link_q.state)
         LNK_HOLD:
         begin
            next_link.dir      = 1'b1;
            next_link.data_out = ULPI_IDLE_BYTE;
            next_link.data_oe  = 1'b1;
            if (lock_s && run_s)
            begin
               next_link.state = LNK_WAIT_STP;
            end
         end
         LNK_WAIT_STP:
         begin
            if (!lock_s)
            begin
               next_link.state = LNK_HOLD;
            end
            else if (!stp)
            begin
               next_link.state   = LNK_RUN;
               next_link.dir     = 1'b0;
               next_link.data_oe = 1'b0;
            end
         end
         LNK_RUN:
         begin
            // synchronous mode running
            // A lost lock takes the bus back rather than clock garbage to the link
            if (!lock_s)
            begin
               next_link.state    = LNK_HOLD;
               next_link.dir      = 1'b1;
               next_link.data_out = ULPI_IDLE_BYTE;
               next_link.data_oe  = 1'b1;
            end
         end
         default:
         begin
            next_link = LINK_INIT;
         end
      endcase
   end

   // Link-side state register
   always_ff @(posedge interface_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         link_q <= LINK_INIT;
      end
      else
      begin
         link_q <= next_link;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign pll_enable            = sys_q.pll_enable;
   assign interface_reset_low   = link_rst_n;
   assign usb_operation_allowed = sys_q.usb_allowed;
   assign register_access_only  = sys_q.reg_only;
   assign uart_regulator_level  = sys_q.reg_level;
   assign dir                   = link_q.dir;
   assign data_out              = link_q.data_out;
   assign data_oe               = link_q.data_oe;

endmodule

// File: tb/phy_startup_checker.sv
// Port assertions for the start-up reset sequencer
`timescale 1ns/1ns
module phy_startup_checker
   import phy_startup_pkg::*;
#(
   parameter int STARTUP_CYCLES = 256
)
(
   // Clocks, resets and inputs
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       interface_clk,
   input wire logic       core_supply_1v8,
   input wire logic       ext_reset_low_pin,
   input wire logic       pll_lock,
   input wire logic       stp,
   input wire logic       uart_mode,
   input wire logic [1:0] uart_level_field,
   // Outputs
   input wire logic       pll_enable,
   input wire logic       interface_reset_low,
   input wire logic       usb_operation_allowed,
   input wire logic       register_access_only,
   input wire logic [1:0] uart_regulator_level,
   input wire logic       dir,
   input wire logic [7:0] data_out,
   input wire logic       data_oe
);
   logic       run;
   logic [4:0] low_cnt;
   // Either mode flag marks the run state
   assign run = usb_operation_allowed || register_access_only;
   // Cycles the pin stayed low; saturates so a long hold stays visible
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         low_cnt <= 5'h00;
      else if (ext_reset_low_pin)
         low_cnt <= 5'h00;
      else if (low_cnt != 5'h1f)
         low_cnt <= low_cnt + 5'h01;
   end
   ////////////////////////////////////////////////////////////
   property p_no_core;
      @(posedge mclk) disable iff (sys_rst) !core_supply_1v8 [*5] |-> !pll_enable && !run;
   endproperty
   a_no_core: assert property (p_no_core) else $error("active without core");
   property p_pin_long;
      @(posedge mclk) disable iff (sys_rst) low_cnt == 5'h1e |-> !pll_enable && !run;
   endproperty
   a_pin_long: assert property (p_pin_long) else $error("pin reset ignored");
   property p_modes;
      @(posedge mclk) disable iff (sys_rst)
      run |-> pll_enable && !(usb_operation_allowed && register_access_only);
   endproperty
   a_modes: assert property (p_modes) else $error("bad mode pair");
   property p_startup;
      @(posedge mclk) disable iff (sys_rst) $rose(run) |-> $past(pll_enable, STARTUP_CYCLES);
   endproperty
   a_startup: assert property (p_startup) else $error("start-up too short");
   property p_uart_off;
      @(posedge mclk) disable iff (sys_rst) !$past(uart_mode) || (!run && !$past(run))
      |-> uart_regulator_level == REG_LEVEL_DEFAULT;
   endproperty
   a_uart_off: assert property (p_uart_off) else $error("level not default");
   property p_uart_on;
      @(posedge mclk) disable iff (sys_rst) $past(uart_mode) && run && $past(run)
      |-> uart_regulator_level == $past(uart_level_field);
   endproperty
   a_uart_on: assert property (p_uart_on) else $error("level not field");
   property p_hold;
      @(posedge interface_clk) disable iff (!interface_reset_low)
      !pll_lock [*5] |-> dir && data_oe && data_out == ULPI_IDLE_BYTE;
   endproperty
   a_hold: assert property (p_hold) else $error("bus not held");
   property p_dir_stp;
      @(posedge interface_clk) disable iff (!interface_reset_low) $fell(dir) |-> !$past(stp);
   endproperty
   a_dir_stp: assert property (p_dir_stp) else $error("dir fell with stp");
endmodule

// File: tb/link_partner.sv
// Behavioural link controller facing the sequencer
`timescale 1ns/1ns
module link_partner
   import phy_startup_pkg::*;
(
   // Clock, supply and bus owner
   input wire logic interface_clk,
   input wire logic core_supply_1v8,
   input wire logic dir,
   // Bench requests
   input wire logic hold_reset,
   input wire logic hold_stp,
   // Link pins
   output logic       ext_reset_low_pin,
   output logic       stp,
   output logic [7:0] link_data,
   output logic       link_oe
);
   assign ext_reset_low_pin = core_supply_1v8 && !hold_reset;
   // Start with stp high and a released bus
   initial
   begin
      stp = 1'b1;
      link_oe = 1'b0;
      link_data = 8'h5a;
   end
   // stp and idle
   // A released bus toggles so a stale idle is never mistaken for a drive
   always @(posedge interface_clk)
   begin
      stp <= hold_stp;
      link_oe <= !dir;
      link_data <= !dir ? ULPI_IDLE_BYTE : ~link_data;
   end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the start-up reset sequencer
`timescale 1ns/1ns
module testbench;
   import phy_startup_pkg::*;
   localparam int SC = 8;
   // Bench-driven inputs
   logic mclk = 1'b0, interface_clk = 1'b0, reference_clock_in = 1'b0, ref_run = 1'b1;
   logic sys_rst = 1'b1, por_done = 1'b1, core_supply_1v8 = 1'b1, io_supply = 1'b1;
   logic usb_supply_3v3 = 1'b1, pll_lock = 1'b0, uart_mode = 1'b0;
   logic hold_reset = 1'b1, hold_stp = 1'b1;
   logic [1:0] uart_level_field = 2'h0;
   // Outputs
   logic ext_reset_low_pin, stp, pll_enable, interface_reset_low, dir, data_oe, link_oe;
   logic usb_operation_allowed, register_access_only;
   logic [1:0] uart_regulator_level;
   logic [7:0] data_out, link_data;
   int   bad_count = 0, n_tests = 0, n;
   // Rows: 3v3, uart, field | usb, register only, level
   logic [7:0] rows [6] = '{8'hb8, 8'hc8, 8'hd9, 8'hea, 8'hfb, 8'h66};
   ////////////////////////////////////////////////////////////
   // Clocks; link and reference edges never meet an mclk edge
   always #20 mclk = ~mclk;
   initial
   begin
      #7;
      forever #80 interface_clk = ~interface_clk;
   end
   initial
   begin
      #5;
      forever #100 reference_clock_in = ref_run ? ~reference_clock_in : 1'b0;
   end
   phy_startup_reset_sequencer #(.STARTUP_CYCLES(SC), .REF_TIMEOUT_CYCLES(40)) dut
   (
      .mclk, .sys_rst, .interface_clk, .por_done, .ext_reset_low_pin, .core_supply_1v8,
      .usb_supply_3v3, .io_supply, .reference_clock_in, .pll_lock, .stp, .uart_mode,
      .uart_level_field, .pll_enable, .interface_reset_low, .usb_operation_allowed,
      .register_access_only, .uart_regulator_level, .dir, .data_out, .data_oe
   );
   link_partner partner
   (
      .interface_clk, .core_supply_1v8, .dir, .hold_reset, .hold_stp, .ext_reset_low_pin,
      .stp, .link_data, .link_oe
   );
   task automatic check1(input string what, input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s is %b", $time, what, got);
      end
   endtask
   task automatic check8(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s is %h", $time, what, got);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // Release the pin, then time the walk from clock enable to run
   task automatic bring_up();
      hold_reset = 1'b0;
      for (n = 0; pll_enable !== 1'b1 && n < 40; n++)
         cyc(1);
      check1("pll enable", pll_enable, 1'b1);
      for (n = 0; (usb_operation_allowed || register_access_only) !== 1'b1 && n < 30; n++)
         cyc(1);
      check8("start-up", 8'(n), 8'(SC));
   endtask
   // Main sequence
   initial
   begin
      cyc(12);
      check1("rst enable", pll_enable, 1'b0);
      check1("rst bus", interface_reset_low, 1'b0);
      sys_rst = 1'b0;
      cyc(40);
      check1("pin low enable", pll_enable, 1'b0);
      check1("pin low bus", interface_reset_low, 1'b0);
      bring_up();
      // Let the link reset release and five lockless link edges pass
      cyc(20);
      check1("dir before lock", dir, 1'b1);
      check1("drive before lock", data_oe, 1'b1);
      check8("idle", data_out, ULPI_IDLE_BYTE);
      pll_lock = 1'b1;
      cyc(20);
      check1("dir with stp", dir, 1'b1);
      hold_stp = 1'b0;
      cyc(16);
      check1("dir handed", dir, 1'b0);
      check1("bus freed", data_oe, 1'b0);
      check1("bus clash", data_oe && link_oe, 1'b0);
      check8("link idle", link_data, ULPI_IDLE_BYTE);
      // Lock lost after hand-over: the device takes the bus back, then returns it
      pll_lock = 1'b0;
      cyc(24);
      check1("dir on lock loss", dir, 1'b1);
      check1("drive on lock loss", data_oe, 1'b1);
      pll_lock = 1'b1;
      cyc(24);
      check1("dir on relock", dir, 1'b0);
      for (int i = 0; i < 6; i++)
      begin
         {usb_supply_3v3, uart_mode, uart_level_field} = rows[i][7:4];
         cyc(6);
         check1("usb mode", usb_operation_allowed, rows[i][3]);
         check1("reg mode", register_access_only, rows[i][2]);
         check8("level", 8'(uart_regulator_level), 8'(rows[i][1:0]));
      end
      usb_supply_3v3 = 1'b1;
      hold_reset = 1'b1;
      cyc(10);
      hold_reset = 1'b0;
      cyc(8);
      check1("short pulse", usb_operation_allowed, 1'b1);
      // A pulse of exactly the minimum width must still reset
      hold_reset = 1'b1;
      cyc(25);
      hold_reset = 1'b0;
      for (n = 0; pll_enable !== 1'b0 && n < 6; n++)
         cyc(1);
      check1("minimum pulse", pll_enable, 1'b0);
      hold_reset = 1'b1;
      cyc(32);
      check1("pin reset", pll_enable, 1'b0);
      check1("pin reset bus", interface_reset_low, 1'b0);
      check8("pin reset level", 8'(uart_regulator_level), 8'h00);
      bring_up();
      {por_done, core_supply_1v8, io_supply} = 3'h0;
      cyc(12);
      check1("no core", usb_operation_allowed, 1'b0);
      check8("no core level", 8'(uart_regulator_level), 8'h00);
      {core_supply_1v8, io_supply} = 2'h3;
      cyc(40);
      check1("no por", pll_enable, 1'b0);
      por_done = 1'b1;
      bring_up();
      hold_reset = 1'b1;
      ref_run = 1'b0;
      // Long enough for the clock watchdog to expire before the pin is released
      cyc(60);
      hold_reset = 1'b0;
      cyc(80);
      check1("no ref clock", pll_enable, 1'b0);
      ref_run = 1'b1;
      bring_up();
      end_of_test();
   end
   // Watchdog far past the whole sequence
   initial
   begin
      #200000;
      bad_count++;
      end_of_test();
   end
endmodule
// Assertions on every sequencer instance
bind phy_startup_reset_sequencer phy_startup_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk
(
   .mclk, .sys_rst, .interface_clk, .core_supply_1v8, .ext_reset_low_pin, .pll_lock, .stp,
   .uart_mode, .uart_level_field, .pll_enable, .interface_reset_low, .usb_operation_allowed,
   .register_access_only, .uart_regulator_level, .dir, .data_out, .data_oe
);
